// file: hdl/pcif_pkg.sv
// Package for the pin change interrupt flag block: map, layouts, types
package pcif_pkg;

	// ==========================================================
	// Register byte offsets (one aligned word each)
	localparam logic [5:0] PCIF_OFF_CORE_CTRL = 6'h00;
	localparam logic [5:0] PCIF_OFF_A_FLAGS = 6'h04;
	localparam logic [5:0] PCIF_OFF_A_FALL = 6'h08;
	localparam logic [5:0] PCIF_OFF_A_RISE = 6'h0c;
	localparam logic [5:0] PCIF_OFF_B_FLAGS = 6'h10;
	localparam logic [5:0] PCIF_OFF_B_FALL = 6'h14;
	localparam logic [5:0] PCIF_OFF_B_RISE = 6'h18;
	localparam logic [5:0] PCIF_OFF_C_FLAGS = 6'h1c;
	localparam logic [5:0] PCIF_OFF_C_FALL = 6'h20;
	localparam logic [5:0] PCIF_OFF_C_RISE = 6'h24;
	localparam logic [5:0] PCIF_OFF_E_FLAGS = 6'h28;
	localparam logic [5:0] PCIF_OFF_E_FALL = 6'h2c;
	localparam logic [5:0] PCIF_OFF_E_RISE = 6'h30;
	localparam logic [5:0] PCIF_OFF_IRQ_STAT = 6'h34;
	localparam logic [5:0] PCIF_OFF_IRQ_MASK = 6'h38;

	// ==========================================================
	// Field positions and reset values
	localparam int PCIF_CTRL_MASTER_EN_BIT = 3;
	localparam int PCIF_CTRL_SUMMARY_BIT = 0;
	localparam logic [7:0] PCIF_CTRL_WR_MASK = 8'h08;
	localparam logic [7:0] PCIF_PORT_E_MASK = 8'h08;
	localparam logic [7:0] PCIF_FULL_MASK = 8'hff;
	localparam logic [7:0] PCIF_REG_RESET = 8'h00;
	localparam int PCIF_IRQ_BITS = 4;
	localparam logic [3:0] PCIF_IRQ_RESET = 4'h0;
	localparam logic [1:0] PCIF_RESP_OKAY = 2'h0;
	localparam logic [1:0] PCIF_RESP_SLVERR = 2'h2;

	// ==========================================================
	// Carrier types
	typedef struct packed
	{
		logic [7:0] flags;
		logic [7:0] fall;
		logic [7:0] rise;
	} pcif_port_s;

	typedef struct packed
	{
		logic awvalid;
		logic [5:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [5:0] araddr;
		logic rready;
	} pcif_axi_req_s;

	typedef struct packed
	{
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} pcif_axi_rsp_s;

endpackage : pcif_pkg

// file: hdl/pcif_port.sv
// One port's edge detectors, enables and sticky change flags
module pcif_port
	import pcif_pkg::*;
#(
	parameter logic [7:0] IMPL_MASK = 8'hff
)
(
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic [7:0] pin_i,
	input wire logic flags_we_i,
	input wire logic fall_we_i,
	input wire logic rise_we_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] flags_o,
	output logic [7:0] fall_o,
	output logic [7:0] rise_o,
	output logic edge_o
);

	// ==========================================================
	// State
	typedef struct packed
	{
		logic [7:0] sync1;
		logic [7:0] sync2;
		logic [7:0] prev;
		logic primed;
		pcif_port_s regs;
	} pcif_pstate_s;

	pcif_pstate_s state;
	pcif_pstate_s next_state;
	logic [7:0] rise_seen;
	logic [7:0] fall_seen;
	logic [7:0] hit;

	// Edges come only from synchronised samples, never the first stage
	assign rise_seen = state.sync2 & ~state.prev & {8{state.primed}};
	assign fall_seen = ~state.sync2 & state.prev & {8{state.primed}};
	assign hit = ((rise_seen & state.regs.rise) | (fall_seen & state.regs.fall)) & IMPL_MASK;

	// Next state: the edge set beats a software write in the same cycle
	always_comb
	begin
		next_state = state;
		next_state.sync1 = pin_i;
		next_state.sync2 = state.sync1;
		next_state.prev = state.sync2;
		next_state.primed = 1'b1;
		if (rise_we_i)
		begin
			next_state.regs.rise = wdata_i & IMPL_MASK;
		end
		if (fall_we_i)
		begin
			next_state.regs.fall = wdata_i & IMPL_MASK;
		end
		if (flags_we_i)
		begin
			next_state.regs.flags = wdata_i & IMPL_MASK;
		end
		next_state.regs.flags = next_state.regs.flags | hit;
	end

	// State register
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state <= '0;
		end
		else
		begin
			state <= next_state;
		end
	end

	assign flags_o = state.regs.flags;
	assign fall_o = state.regs.fall;
	assign rise_o = state.regs.rise;
	assign edge_o = |hit;

	// ==========================================================
	// Assertions
	a_flag_sets_on_hit: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(hit != 8'h00) |=> ((state.regs.flags & $past(hit)) == $past(hit)))
		else $error("Enabled edge did not set its flag");
	a_flag_sticky: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		!flags_we_i |=> ((state.regs.flags & $past(state.regs.flags)) == $past(state.regs.flags)))
		else $error("Flag dropped without a software write");
	a_flag_needs_cause: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(!flags_we_i && hit == 8'h00) |=> $stable(state.regs.flags))
		else $error("Flag changed without an edge or a write");
	a_unimpl_zero: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		((state.regs.flags | state.regs.rise | state.regs.fall) & ~IMPL_MASK) == 8'h00)
		else $error("Unimplemented bit is nonzero");
	a_edge_once: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(rise_seen != 8'h00) |=> ((rise_seen & $past(rise_seen)) == 8'h00))
		else $error("One pin edge seen on two cycles");
	a_clear_works: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(flags_we_i && hit == 8'h00) |=> state.regs.flags == ($past(wdata_i) & IMPL_MASK))
		else $error("Software write did not land in flags");

endmodule : pcif_port

// file: hdl/pcif_top.sv
// Top of the pin change interrupt flag block with its AXI4-Lite slave
module pcif_top
	import pcif_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic [7:0] port_a_pin_i,
	input wire logic [7:0] port_b_pin_i,
	input wire logic [7:0] port_c_pin_i,
	input wire logic [7:0] port_e_pin_i,
	input wire logic s_axi_awvalid_i,
	input wire logic [5:0] s_axi_awaddr_i,
	output logic s_axi_awready_o,
	input wire logic s_axi_wvalid_i,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	output logic s_axi_wready_o,
	output logic s_axi_bvalid_o,
	output logic [1:0] s_axi_bresp_o,
	input wire logic s_axi_bready_i,
	input wire logic s_axi_arvalid_i,
	input wire logic [5:0] s_axi_araddr_i,
	output logic s_axi_arready_o,
	output logic s_axi_rvalid_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	input wire logic s_axi_rready_i,
	output logic change_irq_o,
	output logic wake_o,
	output logic irq_o
);

	// ==========================================================
	// State
	typedef struct packed
	{
		logic aw_got;
		logic [5:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		pcif_axi_rsp_s rsp;
		logic master_en;
		logic [3:0] irq_stat;
		logic [3:0] irq_mask;
	} pcif_tstate_s;

	pcif_tstate_s state;
	pcif_tstate_s next_state;
	pcif_axi_req_s req;
	logic do_write;
	logic wr_lane0;
	logic [7:0] wbyte;
	logic [3:0] port_edge;
	logic [7:0] flag_we;
	logic [7:0] fall_we;
	logic [7:0] rise_we;
	pcif_port_s port_reg [4];
	logic summary;
	logic wr_hit;
	logic rd_hit;
	logic [7:0] rd_byte;
	logic [3:0] stat_after_clear;

	// Bundle the bus request
	always_comb
	begin
		req.awvalid = s_axi_awvalid_i;
		req.awaddr = s_axi_awaddr_i;
		req.wvalid = s_axi_wvalid_i;
		req.wdata = s_axi_wdata_i;
		req.wstrb = s_axi_wstrb_i;
		req.bready = s_axi_bready_i;
		req.arvalid = s_axi_arvalid_i;
		req.araddr = s_axi_araddr_i;
		req.rready = s_axi_rready_i;
	end

	// ==========================================================
	// Write decode: one cycle strobe once address and data are both held
	assign do_write = state.aw_got && state.w_got && !state.rsp.bvalid;
	assign wr_lane0 = do_write && state.w_strb[0];
	assign wbyte = state.w_data[7:0];

	always_comb
	begin
		flag_we = 8'h00;
		fall_we = 8'h00;
		rise_we = 8'h00;
		wr_hit = 1'b1;
		case (state.aw_addr)
			PCIF_OFF_A_FLAGS: flag_we[0] = wr_lane0;
			PCIF_OFF_A_FALL: fall_we[0] = wr_lane0;
			PCIF_OFF_A_RISE: rise_we[0] = wr_lane0;
			PCIF_OFF_B_FLAGS: flag_we[1] = wr_lane0;
			PCIF_OFF_B_FALL: fall_we[1] = wr_lane0;
			PCIF_OFF_B_RISE: rise_we[1] = wr_lane0;
			PCIF_OFF_C_FLAGS: flag_we[2] = wr_lane0;
			PCIF_OFF_C_FALL: fall_we[2] = wr_lane0;
			PCIF_OFF_C_RISE: rise_we[2] = wr_lane0;
			PCIF_OFF_E_FLAGS: flag_we[3] = wr_lane0;
			PCIF_OFF_E_FALL: fall_we[3] = wr_lane0;
			PCIF_OFF_E_RISE: rise_we[3] = wr_lane0;
			PCIF_OFF_CORE_CTRL, PCIF_OFF_IRQ_STAT, PCIF_OFF_IRQ_MASK: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// ==========================================================
	// Four ports; port E keeps only bit 3
	genvar gp;
	generate
		for (gp = 0; gp < 4; gp++)
		begin : g_port
			logic [7:0] pins;
			assign pins = (gp == 0) ? port_a_pin_i : (gp == 1) ? port_b_pin_i :
				(gp == 2) ? port_c_pin_i : port_e_pin_i;
			pcif_port #(
				.IMPL_MASK((gp == 3) ? PCIF_PORT_E_MASK : PCIF_FULL_MASK)
			) u_port (
				.ref_clk_i(ref_clk_i),
				.reset_n_i(reset_n_i),
				.pin_i(pins),
				.flags_we_i(flag_we[gp]),
				.fall_we_i(fall_we[gp]),
				.rise_we_i(rise_we[gp]),
				.wdata_i(wbyte),
				.flags_o(port_reg[gp].flags),
				.fall_o(port_reg[gp].fall),
				.rise_o(port_reg[gp].rise),
				.edge_o(port_edge[gp])
			);
		end
	endgenerate

	// Summary is pure OR, so it tracks flags with no lag
	assign summary = |{port_reg[0].flags, port_reg[1].flags,
		port_reg[2].flags, port_reg[3].flags};
	// Flags never depend on master enable; only the change request and the wake output are gated
	assign change_irq_o = summary && state.master_en;
	// Wake is combinational from the edge so no clock of latency is added
	assign wake_o = (|port_edge) && state.master_en;
	assign irq_o = |(state.irq_stat & state.irq_mask);

	// ==========================================================
	// Read decode
	always_comb
	begin
		rd_hit = 1'b1;
		rd_byte = 8'h00;
		case (req.araddr)
			PCIF_OFF_CORE_CTRL:
			begin
				rd_byte[PCIF_CTRL_MASTER_EN_BIT] = state.master_en;
				rd_byte[PCIF_CTRL_SUMMARY_BIT] = summary;
			end
			PCIF_OFF_A_FLAGS: rd_byte = port_reg[0].flags;
			PCIF_OFF_A_FALL: rd_byte = port_reg[0].fall;
			PCIF_OFF_A_RISE: rd_byte = port_reg[0].rise;
			PCIF_OFF_B_FLAGS: rd_byte = port_reg[1].flags;
			PCIF_OFF_B_FALL: rd_byte = port_reg[1].fall;
			PCIF_OFF_B_RISE: rd_byte = port_reg[1].rise;
			PCIF_OFF_C_FLAGS: rd_byte = port_reg[2].flags;
			PCIF_OFF_C_FALL: rd_byte = port_reg[2].fall;
			PCIF_OFF_C_RISE: rd_byte = port_reg[2].rise;
			PCIF_OFF_E_FLAGS: rd_byte = port_reg[3].flags;
			PCIF_OFF_E_FALL: rd_byte = port_reg[3].fall;
			PCIF_OFF_E_RISE: rd_byte = port_reg[3].rise;
			PCIF_OFF_IRQ_STAT: rd_byte = {4'h0, state.irq_stat};
			PCIF_OFF_IRQ_MASK: rd_byte = {4'h0, state.irq_mask};
			default: rd_hit = 1'b0;
		endcase
	end

	// Write-one-to-clear, but a same-cycle event wins
	assign stat_after_clear = (do_write && state.w_strb[0] && state.aw_addr == PCIF_OFF_IRQ_STAT)
		? (state.irq_stat & ~wbyte[3:0]) : state.irq_stat;

	// ==========================================================
	// Bus handshakes and control registers
	always_comb
	begin
		next_state = state;
		next_state.irq_stat = stat_after_clear | port_edge;
		if (req.awvalid && !state.aw_got)
		begin
			next_state.aw_got = 1'b1;
			next_state.aw_addr = req.awaddr;
		end
		if (req.wvalid && !state.w_got)
		begin
			next_state.w_got = 1'b1;
			next_state.w_data = req.wdata;
			next_state.w_strb = req.wstrb;
		end
		if (do_write)
		begin
			next_state.rsp.bvalid = 1'b1;
			next_state.rsp.bresp = wr_hit ? PCIF_RESP_OKAY : PCIF_RESP_SLVERR;
			if (state.w_strb[0] && state.aw_addr == PCIF_OFF_CORE_CTRL)
			begin
				next_state.master_en = wbyte[PCIF_CTRL_MASTER_EN_BIT];
			end
			if (state.w_strb[0] && state.aw_addr == PCIF_OFF_IRQ_MASK)
			begin
				next_state.irq_mask = wbyte[3:0];
			end
		end
		if (state.rsp.bvalid && req.bready)
		begin
			next_state.rsp.bvalid = 1'b0;
			next_state.aw_got = 1'b0;
			next_state.w_got = 1'b0;
		end
		if (req.arvalid && !state.rsp.rvalid)
		begin
			next_state.rsp.rvalid = 1'b1;
			next_state.rsp.rdata = {24'h000000, rd_byte};
			next_state.rsp.rresp = rd_hit ? PCIF_RESP_OKAY : PCIF_RESP_SLVERR;
		end
		if (state.rsp.rvalid && req.rready)
		begin
			next_state.rsp.rvalid = 1'b0;
		end
		next_state.rsp.awready = 1'b0;
		next_state.rsp.wready = 1'b0;
		next_state.rsp.arready = 1'b0;
	end

	// State register
	always_ff @(posedge ref_clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state <= '0;
		end
		else
		begin
			state <= next_state;
		end
	end

	// Ready lines are combinational; each channel accepts one item until the response
	assign s_axi_awready_o = !state.aw_got;
	assign s_axi_wready_o = !state.w_got;
	assign s_axi_arready_o = !state.rsp.rvalid;
	assign s_axi_bvalid_o = state.rsp.bvalid;
	assign s_axi_bresp_o = state.rsp.bresp;
	assign s_axi_rvalid_o = state.rsp.rvalid;
	assign s_axi_rdata_o = state.rsp.rdata;
	assign s_axi_rresp_o = state.rsp.rresp;

	// ==========================================================
	// Assertions
	// A wake pulse with no bus write in the same cycle must leave the change request standing one cycle later
	sequence s_edge_enabled;
		(|port_edge) && state.master_en;
	endsequence

	sequence s_irq_follows;
		##1 change_irq_o;
	endsequence

	// Summary is raised by any enabled edge, and only a flag write may drop it
	a_summary_sets: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(|port_edge) |=> summary)
		else $error("Summary flag not set by an edge");
	a_summary_tracks: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(summary && flag_we == 8'h00) |=> summary)
		else $error("Summary flag dropped without a flag write");
	a_master_gates: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		!state.master_en |-> !change_irq_o && !wake_o)
		else $error("Request raised with master enable clear");
	a_detect_no_master: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(|port_edge) && !state.master_en |=> summary)
		else $error("Edge lost while master enable clear");
	a_wake_irq: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(s_edge_enabled and !do_write) |-> s_irq_follows)
		else $error("Wake edge did not raise change request");
	a_set_beats_clear: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(port_edge[0] && flag_we[0]) |=> port_reg[0].flags != 8'h00)
		else $error("Edge lost during flag write");
	a_stat_set_wins: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(port_edge != 4'h0) |=> ((state.irq_stat & $past(port_edge)) == $past(port_edge)))
		else $error("Edge event lost in interrupt status");
	a_unimpl_port_e: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		(port_reg[3].flags & ~PCIF_PORT_E_MASK) == 8'h00)
		else $error("Port E unimplemented flag bit set");

endmodule : pcif_top

// file: verif/pcif_pin_model.sv
// Behavioural model of the external digital input pins feeding the block
module pcif_pin_model
(
	input wire logic ref_clk_i,
	input wire logic load_i,
	input wire logic [31:0] level_i,
	output logic [7:0] port_a_o,
	output logic [7:0] port_b_o,
	output logic [7:0] port_c_o,
	output logic [7:0] port_e_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// ==========================================================
	// Pin levels
	// Pins start low so the first commanded rise is a real edge
	initial
	begin
		{port_a_o, port_b_o, port_c_o, port_e_o} = 32'h0;
	end

	// Levels move well off the clock edge, as truly asynchronous pins would
	always @(posedge ref_clk_i)
	begin
		if (load_i)
		begin
			{port_a_o, port_b_o, port_c_o, port_e_o} <= #23 level_i;
		end
	end
endmodule : pcif_pin_model

// file: verif/testbench.sv
// Self-checking testbench for the pin change interrupt flag block
module testbench;
	import pcif_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	// ==========================================================
	// Signals
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] pa, pb, pc, pe;
	logic load = 1'b0;
	logic [31:0] level = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [5:0] awaddr = 6'h0, araddr = 6'h0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'hf;
	logic awready, wready, bvalid, arready, rvalid, chg_irq, wake, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [33:0] exp_q[$];
	logic [7:0] c_rise;
	logic [5:0] flag_offs[4] = '{PCIF_OFF_A_FLAGS, PCIF_OFF_B_FLAGS, PCIF_OFF_C_FLAGS,
		PCIF_OFF_E_FLAGS};
	int seed = 32'h813692de;
	int miscompares = 0;
	int n_checks = 0;
	int cycles = 0;
	int wake_n = 0;

	// ==========================================================
	// Clock, reset, design and pin model
	initial
	begin
		forever #50 clk = ~clk;
	end

	initial
	begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
	end

	pcif_top u_dut (.ref_clk_i(clk), .reset_n_i(rst_n), .port_a_pin_i(pa), .port_b_pin_i(pb),
		.port_c_pin_i(pc), .port_e_pin_i(pe), .s_axi_awvalid_i(awvalid),
		.s_axi_awaddr_i(awaddr), .s_axi_awready_o(awready), .s_axi_wvalid_i(wvalid),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wready_o(wready),
		.s_axi_bvalid_o(bvalid), .s_axi_bresp_o(bresp), .s_axi_bready_i(bready),
		.s_axi_arvalid_i(arvalid), .s_axi_araddr_i(araddr), .s_axi_arready_o(arready),
		.s_axi_rvalid_o(rvalid), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rready_i(rready), .change_irq_o(chg_irq), .wake_o(wake), .irq_o(irq));

	pcif_pin_model u_pins (.ref_clk_i(clk), .load_i(load), .level_i(level), .port_a_o(pa),
		.port_b_o(pb), .port_c_o(pc), .port_e_o(pe));

	// ==========================================================
	// Checking and closing
	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("ERROR %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : results

	// Responses are compared in arrival order; one transfer at a time keeps order exact
	always @(posedge clk)
	begin
		cycles++;
		if (wake === 1'b1)
			wake_n++;
		if (bvalid === 1'b1 && bready === 1'b1)
			check({bresp, 32'h0}, exp_q.pop_front());
		if (rvalid === 1'b1 && rready === 1'b1)
			check({rresp, rdata}, exp_q.pop_front());
		if (cycles == 6000)
		begin
			miscompares++;
			results();
		end
	end

	// ==========================================================
	// Bus and pin tasks
	// Each task first lets an edge pass so no signal is assigned twice in one step
	task automatic axi_write(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
		bit aw_p, w_p;
		@(posedge clk);
		exp_q.push_back({r, 32'h0});
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aw_p = 1;
		w_p = 1;
		do
		begin
			@(posedge clk);
			if (aw_p && awready === 1'b1)
			begin
				aw_p = 0;
				awvalid <= 1'b0;
			end
			if (w_p && wready === 1'b1)
			begin
				w_p = 0;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask : axi_write

	task automatic axi_read(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge clk);
		exp_q.push_back({r, d});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (arvalid === 1'b1 && arready === 1'b1)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		rready <= 1'b0;
	endtask : axi_read

	// Allow the two-stage synchroniser and the flag register to settle
	task automatic set_pins(input logic [31:0] v);
		@(posedge clk);
		load <= 1'b1;
		level <= v;
		@(posedge clk);
		load <= 1'b0;
		repeat (8) @(posedge clk);
	endtask : set_pins

	// ==========================================================
	// Main sequence
	initial
	begin
		c_rise = 8'($random(seed)) | 8'h01;
		@(posedge rst_n);
		for (int i = 0; i < 15; i++)
			axi_read(6'(i * 4), 32'h0, PCIF_RESP_OKAY);
		// Enables: A rising only, B falling only, C random rising, E both
		axi_write(PCIF_OFF_A_RISE, 32'hff, PCIF_RESP_OKAY);
		axi_write(PCIF_OFF_B_FALL, 32'hff, PCIF_RESP_OKAY);
		axi_write(PCIF_OFF_C_RISE, {24'h0, c_rise}, PCIF_RESP_OKAY);
		axi_write(PCIF_OFF_E_RISE, 32'hffffffff, PCIF_RESP_OKAY);
		axi_write(PCIF_OFF_E_FALL, 32'hff, PCIF_RESP_OKAY);
		axi_read(PCIF_OFF_A_RISE, 32'hff, PCIF_RESP_OKAY);
		axi_read(PCIF_OFF_C_RISE, {24'h0, c_rise}, PCIF_RESP_OKAY);
		axi_read(PCIF_OFF_E_RISE, 32'h08, PCIF_RESP_OKAY);
		axi_read(PCIF_OFF_E_FALL, 32'h08, PCIF_RESP_OKAY);
		axi_write(6'h3c, 32'hff, PCIF_RESP_SLVERR);
		axi_read(6'h3c, 32'h0, PCIF_RESP_SLVERR);
		// Rising edges on every pin with the master enable still clear
		set_pins(32'hffffffff);
		axi_read(PCIF_OFF_A_FLAGS, 32'hff, PCIF_RESP_OKAY);
		axi_read(PCIF_OFF_B_FLAGS, 32'h0, PCIF_RESP_OKAY);
		axi_read(PCIF_OFF_C_FLAGS, {24'h0, c_rise}, PCIF_RESP_OKAY);
		axi_read(PCIF_OFF_E_FLAGS, 32'h08, PCIF_RESP_OKAY);
		axi_read(PCIF_OFF_CORE_CTRL, 32'h01, PCIF_RESP_OKAY);
		check({33'h0, chg_irq}, 34'h0);
		axi_read(PCIF_OFF_IRQ_STAT, 32'h0d, PCIF_RESP_OKAY);
		// Master enable on; the summary bit is read-only
		axi_write(PCIF_OFF_CORE_CTRL, 32'hff, PCIF_RESP_OKAY);
		axi_read(PCIF_OFF_CORE_CTRL, 32'h09, PCIF_RESP_OKAY);
		check({33'h0, chg_irq}, 34'h1);
		check({33'h0, irq}, 34'h0);
		axi_write(PCIF_OFF_IRQ_MASK, 32'h0f, PCIF_RESP_OKAY);
		// Lane 0 strobe low: the write is answered but leaves the mask alone
		wstrb <= 4'he;
		axi_write(PCIF_OFF_IRQ_MASK, 32'h0, PCIF_RESP_OKAY);
		wstrb <= 4'hf;
		axi_read(PCIF_OFF_IRQ_MASK, 32'h0f, PCIF_RESP_OKAY);
		check({33'h0, irq}, 34'h1);
		axi_write(PCIF_OFF_IRQ_STAT, 32'h0f, PCIF_RESP_OKAY);
		axi_read(PCIF_OFF_IRQ_STAT, 32'h0, PCIF_RESP_OKAY);
		check({33'h0, irq}, 34'h0);
		// Falling edges everywhere: only B and E respond, A keeps its flags
		set_pins(32'h0);
		axi_read(PCIF_OFF_B_FLAGS, 32'hff, PCIF_RESP_OKAY);
		axi_read(PCIF_OFF_A_FLAGS, 32'hff, PCIF_RESP_OKAY);
		axi_read(PCIF_OFF_IRQ_STAT, 32'h0a, PCIF_RESP_OKAY);
		check({33'h0, wake_n != 0}, 34'h1);
		// Software clears every flag by writing zero; stable pins must not set them again
		foreach (flag_offs[i])
			axi_write(flag_offs[i], 32'h0, PCIF_RESP_OKAY);
		repeat (6) @(posedge clk);
		foreach (flag_offs[i])
			axi_read(flag_offs[i], 32'h0, PCIF_RESP_OKAY);
		axi_read(PCIF_OFF_CORE_CTRL, 32'h08, PCIF_RESP_OKAY);
		check({33'h0, chg_irq}, 34'h0);
		// Pin A0 rises in the very cycle that a zero is written to the port A flags
		fork
			set_pins(32'h01000000);
			begin
				repeat (2) @(posedge clk);
				axi_write(PCIF_OFF_A_FLAGS, 32'h0, PCIF_RESP_OKAY);
			end
		join
		axi_read(PCIF_OFF_A_FLAGS, 32'h01, PCIF_RESP_OKAY);
		axi_read(PCIF_OFF_CORE_CTRL, 32'h09, PCIF_RESP_OKAY);
		check({33'h0, chg_irq}, 34'h1);
		repeat (2) @(posedge clk);
		results();
	end
endmodule : testbench
